// ==== frame_port_consts.vh ====
`ifndef FRAME_PORT_CONSTS_VH
`define FRAME_PORT_CONSTS_VH

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define FRAME_BITS      5'd24
`define FB_BANK         23
`define FB_READ         22
`define FB_ADDR_HI      19
`define FB_ADDR_LO      16
`define FB_SEL_HI       15
`define FB_SEL_LO       14
`define FB_DATA_HI      13
`define FB_HDR_LO       14
`define SEL_DATA        2'h3
`define SEL_OFFSET      2'h2
`define SEL_GAIN        2'h1
`define SEL_SPECIAL     2'h0
`define CMD_NOP         4'h0

// ----------------------------------------------------------------------------
// Register map, byte addresses
// ----------------------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_LAST_WORD   8'h08
`define OFS_SPECIAL     8'h0C
`define OFS_MEM_INDEX   8'h10
`define OFS_MEM_DATA    8'h14
`define CTRL_TOGGLE_BIT 0
`define CTRL_RES12_BIT  1
`define ST_RB_PEND_BIT  0
`define ST_CHAIN_BIT    1
`define ST_ACTIVE_BIT   2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_DATA        14'h0000
`define RST_OFFSET      14'h2000
`define RST_GAIN        14'h3FFE
`define RST_CTRL        2'h0

`endif

// ==== pin_sync_edge.v ====
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------------
// Two-stage pin synchroniser with registered edge flags
// ----------------------------------------------------------------------------
module pin_sync_edge #(
    parameter IDLE = 1'b0
) (
    input  wire core_clk, // System clock.
    input  wire rst_b,    // Synchronous reset, active low.
    input  wire pin_in,   // Raw pin from outside the clock domain.
    output reg  level_r,  // Synchronised level.
    output reg  rise_r,   // One-cycle pulse on a rising edge.
    output reg  fall_r    // One-cycle pulse on a falling edge.
);

    reg meta_r;
    reg stage_r;

    always @(posedge core_clk) begin
        if (!rst_b) begin
            meta_r  <= IDLE;
            stage_r <= IDLE;
            level_r <= IDLE;
            rise_r  <= 1'b0;
            fall_r  <= 1'b0;
        end else begin
            meta_r  <= pin_in;
            stage_r <= meta_r;
            level_r <= stage_r;
            rise_r  <= stage_r & ~level_r;
            fall_r  <= ~stage_r & level_r;
        end
    end

endmodule

`default_nettype wire

// ==== frame_port.v ====
`timescale 1ns/10ps
`default_nettype none
`include "frame_port_consts.vh"

module frame_port (
    input  wire        core_clk,         // System clock, 50 MHz.
    input  wire        rst_b,            // Synchronous reset, active low.
    input  wire        frame_sel_b,      // Frame select pin, active low.
    input  wire        serial_clk,       // Serial clock pin from the host.
    input  wire        serial_in,        // Serial data pin.
    input  wire        chain_enable_pin, // High selects chain mode.
    output reg         chain_out,        // Serial data out / chain output.
    input  wire [7:0]  address,          // Avalon byte address.
    input  wire        read,             // Avalon read request.
    input  wire        write,            // Avalon write request.
    input  wire [31:0] writedata,        // Avalon write data.
    output reg  [31:0] readdata,         // Avalon read data.
    output reg         waitrequest       // Avalon wait request.
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    wire fs_lvl;
    wire fs_rise;
    wire fs_fall;
    wire sck_rise;
    wire sck_fall;
    wire din_lvl;
    wire chain_lvl;

    pin_sync_edge #(.IDLE(1'b1)) u_fs (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pin_in   (frame_sel_b),
        .level_r  (fs_lvl),
        .rise_r   (fs_rise),
        .fall_r   (fs_fall)
    );

    // The host parks the serial clock high, so the synchroniser starts high too
    // and no false edge follows reset.
    pin_sync_edge #(.IDLE(1'b1)) u_sck (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pin_in   (serial_clk),
        .level_r  (),
        .rise_r   (sck_rise),
        .fall_r   (sck_fall)
    );

    pin_sync_edge #(.IDLE(1'b0)) u_din (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pin_in   (serial_in),
        .level_r  (din_lvl),
        .rise_r   (),
        .fall_r   ()
    );

    pin_sync_edge #(.IDLE(1'b0)) u_chain (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pin_in   (chain_enable_pin),
        .level_r  (chain_lvl),
        .rise_r   (),
        .fall_r   ()
    );

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function [5:0] slot_index;
        input [3:0] ch;
        input [1:0] sel;
        input       bank;
        begin
            case (sel)
                `SEL_OFFSET: slot_index = {ch, 2'h2};
                `SEL_GAIN:   slot_index = {ch, 2'h3};
                default:     slot_index = {ch, 1'b0, bank};
            endcase
        end
    endfunction

    function [13:0] slot_default;
        input [1:0] slot;
        begin
            case (slot)
                2'h2:    slot_default = `RST_OFFSET;
                2'h3:    slot_default = `RST_GAIN;
                default: slot_default = `RST_DATA;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg [23:0] shift_r;
    reg [23:0] rb_sr_r;
    reg [23:0] rb_word_r;
    reg [23:0] last_word_r;
    reg [4:0]  bit_cnt_r;
    reg        active_r;
    reg        rb_pend_r;
    reg [7:0]  good_cnt_r;
    reg [7:0]  bad_cnt_r;
    reg [3:0]  special_cmd_r;
    reg [7:0]  special_cnt_r;
    reg [1:0]  ctrl_r;
    reg [5:0]  mem_index_r;
    reg [13:0] slot_mem [0:63];
    integer    i;

    wire toggle_en = ctrl_r[`CTRL_TOGGLE_BIT];
    wire res12     = ctrl_r[`CTRL_RES12_BIT];
    wire cnt_full  = (bit_cnt_r >= `FRAME_BITS);

    // The standalone frame closes on its 24th bit; the chain frame on the
    // frame-select rise, so that 24 or more bits may pass through first; fewer count as a bad frame.
    wire std_done   = !chain_lvl && active_r && sck_fall && !fs_lvl && !fs_fall
                      && (bit_cnt_r == `FRAME_BITS - 5'd1);
    wire chain_done = chain_lvl && active_r && fs_rise && cnt_full;
    wire chain_bad  = chain_lvl && active_r && fs_rise && !cnt_full;
    wire commit     = std_done || chain_done;
    wire [23:0] word = std_done ? {shift_r[22:0], din_lvl} : shift_r;

    wire        w_read = word[`FB_READ];
    wire [3:0]  w_addr = word[`FB_ADDR_HI:`FB_ADDR_LO];
    wire [1:0]  w_sel  = word[`FB_SEL_HI:`FB_SEL_LO];
    wire        w_bank = toggle_en & word[`FB_BANK];
    wire [5:0]  w_slot = slot_index(w_addr, w_sel, w_bank);
    // Twelve-bit layout keeps the data in the upper field bits.
    wire [13:0] w_data = res12 ? {2'h0, word[13:2]} : word[13:0];
    wire [13:0] w_mem  = slot_mem[w_slot];
    wire [13:0] rb_val = (w_sel == `SEL_SPECIAL) ? 14'h0000 :
                         (res12 ? {w_mem[11:0], 2'h0} : w_mem);

    // ------------------------------------------------------------------------
    // Frame reception
    // ------------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!rst_b) begin
            shift_r   <= 24'h000000;
            bit_cnt_r <= 5'h00;
            active_r  <= 1'b0;
        end else if (fs_fall) begin
            bit_cnt_r <= 5'h00;
            active_r  <= 1'b1;
        end else if (active_r && !fs_lvl && sck_fall) begin
            if (chain_lvl || !cnt_full) begin
                shift_r <= {shift_r[22:0], din_lvl};
            end
            if (bit_cnt_r != 5'h1F) begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
            if (std_done) begin
                active_r <= 1'b0;
            end
        end else if (fs_rise && chain_lvl) begin
            active_r <= 1'b0;
        end
    end
    // Standalone frame-select rises fall through above untouched.

    // ------------------------------------------------------------------------
    // Register update and readback request
    // ------------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!rst_b) begin
            for (i = 0; i < 64; i = i + 1) begin
                slot_mem[i] <= slot_default(i[1:0]);
            end
            rb_word_r     <= 24'h000000;
            last_word_r   <= 24'h000000;
            good_cnt_r    <= 8'h00;
            bad_cnt_r     <= 8'h00;
            special_cmd_r <= `CMD_NOP;
            special_cnt_r <= 8'h00;
        end else begin
            if (chain_bad) begin
                bad_cnt_r <= bad_cnt_r + 8'h01;
            end
            if (commit) begin
                good_cnt_r  <= good_cnt_r + 8'h01;
                last_word_r <= word;
                if (w_read) begin
                    rb_word_r <= {word[23:`FB_HDR_LO], rb_val};
                end else if (w_sel == `SEL_SPECIAL) begin
                    if (w_addr != `CMD_NOP) begin
                        special_cmd_r <= w_addr;
                        special_cnt_r <= special_cnt_r + 8'h01;
                    end
                end else begin
                    slot_mem[w_slot] <= w_data;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------------------
    // Set wins over consume: a read request committing in the same cycle as a
    // new frame-select fall stays pending for the frame after.
    always @(posedge core_clk) begin
        if (!rst_b) begin
            rb_pend_r <= 1'b0;
            rb_sr_r   <= 24'h000000;
            chain_out <= 1'b0;
        end else begin
            if (fs_fall) begin
                rb_sr_r   <= rb_pend_r ? rb_word_r : 24'h000000;
                chain_out <= rb_pend_r & rb_word_r[23];
            end else if (active_r && !fs_lvl && sck_rise && bit_cnt_r != 5'h00) begin
                if (chain_lvl && cnt_full) begin
                    chain_out <= shift_r[23];
                end else begin
                    chain_out <= rb_sr_r[22];
                end
                rb_sr_r <= {rb_sr_r[22:0], 1'b0};
            end else if (fs_rise) begin
                chain_out <= 1'b0;
            end
            if (commit && w_read) begin
                rb_pend_r <= 1'b1;
            end else if (fs_fall) begin
                rb_pend_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Avalon-MM slave, one wait cycle per access
    // ------------------------------------------------------------------------
    reg [31:0] rd_mux;

    always @* begin
        case (address)
            `OFS_CTRL:      rd_mux = {30'h0, ctrl_r};
            `OFS_STATUS:    rd_mux = {bad_cnt_r, good_cnt_r, 13'h0, active_r,
                                      chain_lvl, rb_pend_r};
            `OFS_LAST_WORD: rd_mux = {8'h00, last_word_r};
            `OFS_SPECIAL:   rd_mux = {16'h0, special_cnt_r, 4'h0, special_cmd_r};
            `OFS_MEM_INDEX: rd_mux = {26'h0, mem_index_r};
            `OFS_MEM_DATA:  rd_mux = {18'h0, slot_mem[mem_index_r]};
            default:        rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge core_clk) begin
        if (!rst_b) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h00000000;
            ctrl_r      <= `RST_CTRL;
            mem_index_r <= 6'h00;
        end else begin
            if ((read || write) && waitrequest) begin
                waitrequest <= 1'b0;
                if (read) begin
                    readdata <= rd_mux;
                end
            end else begin
                waitrequest <= 1'b1;
            end
            // The write lands on the edge where the master sees the answer.
            if (write && !waitrequest) begin
                case (address)
                    `OFS_CTRL:      ctrl_r      <= writedata[1:0];
                    `OFS_MEM_INDEX: mem_index_r <= writedata[5:0];
                    default:        ;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ==== frame_port_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "frame_port_consts.vh"
// ----------------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------------
module frame_port_chk (
    input wire logic        core_clk,    // System clock.
    input wire logic        rst_b,       // Synchronous reset, active low.
    input wire logic        frame_sel_b, // Frame select pin.
    input wire logic        serial_clk,  // Serial clock pin.
    input wire logic        chain_out,   // Serial out.
    input wire logic [7:0]  address,     // Bus address.
    input wire logic        read,        // Bus read.
    input wire logic        write,       // Bus write.
    input wire logic [31:0] readdata,    // Bus read data.
    input wire logic        waitrequest  // Bus wait request.
);
    // Pins are raw, so edges are judged by their own sampled history.
    logic       sc_q_r;
    logic       fs_q_r;
    logic [3:0] since_r;
    logic [3:0] high_r;
    always_ff @(posedge core_clk) begin
        sc_q_r <= serial_clk;
        fs_q_r <= frame_sel_b;
        if (!rst_b || sc_q_r != serial_clk || fs_q_r != frame_sel_b) since_r <= 4'h0;
        else if (since_r != 4'hF) since_r <= since_r + 4'h1;
        if (!rst_b || !frame_sel_b) high_r <= 4'h0;
        else if (high_r != 4'hF) high_r <= high_r + 4'h1;
    end
    default clocking cb @(posedge core_clk); endclocking
    property p_ack;
        disable iff (!rst_b) (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_ack: assert property (p_ack) else $error("bus request not answered next cycle");
    property p_one;
        disable iff (!rst_b) !waitrequest |=> waitrequest;
    endproperty
    a_one: assert property (p_one) else $error("waitrequest low longer than one cycle");
    property p_cause;
        disable iff (!rst_b) $fell(waitrequest) |-> $past(read || write);
    endproperty
    a_cause: assert property (p_cause) else $error("answer without a request");
    property p_hold;
        disable iff (!rst_b) $changed(readdata) |-> !waitrequest && $past(read);
    endproperty
    a_hold: assert property (p_hold) else $error("readdata changed outside a read answer");
    property p_unmap;
        disable iff (!rst_b) !waitrequest && $past(read) && $past(address) > 8'h14
            |-> readdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_ctrl;
        disable iff (!rst_b) !waitrequest && $past(read) && $past(address) == `OFS_CTRL
            |-> readdata[31:2] == 30'h0;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control upper bits not zero");
    property p_rst;
        !rst_b |=> waitrequest && readdata == 32'h0 && !chain_out;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not at reset values");
    property p_quiet;
        disable iff (!rst_b) high_r >= 4'h8 |-> !chain_out;
    endproperty
    a_quiet: assert property (p_quiet) else $error("serial out driven outside a frame");
    property p_edge;
        disable iff (!rst_b) $changed(chain_out) |-> since_r < 4'h8;
    endproperty
    a_edge: assert property (p_edge) else $error("serial out moved without a pin edge");
    c_rd: cover property (!waitrequest && $past(read));
    c_out: cover property ($rose(chain_out));
    c_wr: cover property (!waitrequest && $past(write));
endmodule
bind frame_port frame_port_chk u_chk (.core_clk(core_clk), .rst_b(rst_b),
    .frame_sel_b(frame_sel_b), .serial_clk(serial_clk), .chain_out(chain_out),
    .address(address), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest));
`default_nettype wire

// ==== frame_host.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Host controller model
// ----------------------------------------------------------------------------
module frame_host (
    input wire logic core_clk,    // System clock.
    input wire logic chain_out,   // Serial out of the device.
    output var logic frame_sel_b, // Frame select, active low.
    output var logic serial_clk,  // Serial clock, idles high.
    output var logic serial_in    // Serial data to the device.
);
    // The interface-select strap is taken as high: only the clocked serial mode exists.
    initial begin
        frame_sel_b = 1'b1;
        serial_clk = 1'b1;
        serial_in = 1'b0;
    end
    // Gated burst of exactly n clocks; each phase is four core cycles.
    task automatic frame(input logic [47:0] w, input int n, output logic [47:0] rx);
        rx = 48'h0;
        frame_sel_b <= 1'b0;
        serial_in <= w[n-1];
        repeat (4) @(posedge core_clk);
        for (int i = n - 1; i >= 0; i--) begin
            serial_clk <= 1'b0;
            @(posedge core_clk);
            rx = {rx[46:0], chain_out};
            repeat (3) @(posedge core_clk);
            serial_clk <= 1'b1;
            if (i > 0) serial_in <= w[i-1];
            repeat (4) @(posedge core_clk);
        end
        frame_sel_b <= 1'b1;
        serial_in <= ~serial_in;
        repeat (8) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// ==== test_frame_port.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "frame_port_consts.vh"
module test_frame_port;
    logic        core_clk, rst_b, chain_enable_pin, read, write, waitrequest;
    logic        frame_sel_b, serial_clk, serial_in, chain_out;
    logic [7:0]  address;
    logic [31:0] writedata, readdata, d;
    logic [47:0] rx;
    logic [23:0] rb;
    int          n_errors, compares;
    frame_port dut (.core_clk(core_clk), .rst_b(rst_b), .frame_sel_b(frame_sel_b),
        .serial_clk(serial_clk), .serial_in(serial_in), .chain_enable_pin(chain_enable_pin),
        .chain_out(chain_out), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
    frame_host u_host (.core_clk(core_clk), .chain_out(chain_out),
        .frame_sel_b(frame_sel_b), .serial_clk(serial_clk), .serial_in(serial_in));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task chk(input string nm, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task bus(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
        address <= a;
        writedata <= wd;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge core_clk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge core_clk);
    endtask
    task mem(input logic [5:0] idx, input logic [13:0] exp);
        bus(`OFS_MEM_INDEX, 1'b1, {26'h0, idx}, d);
        bus(`OFS_MEM_DATA, 1'b0, 32'h0, d);
        chk("mem", {18'h0, exp}, d);
    endtask
    function automatic logic [23:0] fw(input logic b, r, input logic [3:0] c,
                                       input logic [1:0] s, input logic [13:0] v);
        return {b, r, 2'b00, c, s, v};
    endfunction
    task results;
        if (n_errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        results;
    end
    initial begin
        rst_b = 1'b0;
        chain_enable_pin = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0;
        n_errors = 0;
        compares = 0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        bus(`OFS_CTRL, 1'b0, 32'h0, d);
        chk("ctrl", 32'h0, d);
        bus(8'h40, 1'b1, 32'hFFFF_FFFF, d);
        bus(8'h40, 1'b0, 32'h0, d);
        chk("unmapped", 32'h0, d);
        mem({4'h5, 2'h2}, `RST_OFFSET);
        mem({4'h5, 2'h3}, `RST_GAIN);
        for (int s = 1; s < 4; s++) begin
            u_host.frame({24'h0, fw(1'b0, 1'b0, 4'h5, s[1:0], 14'h1000 + s)}, 24, rx);
            mem({4'h5, (s == 3) ? 2'h0 : 2'(4 - s)}, 14'h1000 + s);
        end
        u_host.frame({24'h0, fw(1'b1, 1'b0, 4'h5, 2'h3, 14'h0AAA)}, 24, rx);
        mem({4'h5, 2'h0}, 14'h0AAA);
        bus(`OFS_CTRL, 1'b1, 32'h1, d);
        u_host.frame({24'h0, fw(1'b1, 1'b0, 4'h5, 2'h3, 14'h1555)}, 24, rx);
        mem({4'h5, 2'h1}, 14'h1555);
        mem({4'h5, 2'h0}, 14'h0AAA);
        u_host.frame(48'h3FF, 10, rx);
        u_host.frame({22'h0, fw(1'b0, 1'b0, 4'h5, 2'h3, 14'h2222), 2'b11}, 26, rx);
        mem({4'h5, 2'h0}, 14'h2222);
        u_host.frame({24'h0, fw(1'b0, 1'b0, 4'h1, 2'h0, 14'h0)}, 24, rx);
        bus(`OFS_SPECIAL, 1'b0, 32'h0, d);
        chk("special", 32'h0101, d);
        rb = fw(1'b0, 1'b1, 4'h5, 2'h1, 14'h3FFF);
        u_host.frame({24'h0, rb}, 24, rx);
        u_host.frame(48'h0, 24, rx);
        chk("readback", {8'h0, rb[23:14], 14'h1001}, {8'h0, rx[23:0]});
        mem({4'h5, 2'h3}, 14'h1001);
        bus(`OFS_SPECIAL, 1'b0, 32'h0, d);
        chk("special", 32'h0101, d);
        bus(`OFS_CTRL, 1'b1, 32'h3, d);
        u_host.frame({24'h0, fw(1'b0, 1'b0, 4'h5, 2'h2, 14'h2AF3)}, 24, rx);
        rb = fw(1'b0, 1'b1, 4'h5, 2'h2, 14'h0);
        u_host.frame({24'h0, rb}, 24, rx);
        u_host.frame(48'h0, 24, rx);
        chk("res12", {8'h0, rb[23:14], 14'h2AF0}, {8'h0, rx[23:0]});
        bus(`OFS_CTRL, 1'b1, 32'h0, d);
        chain_enable_pin <= 1'b1;
        repeat (8) @(posedge core_clk);
        bus(`OFS_STATUS, 1'b0, 32'h0, d);
        chk("chain_pin", 32'h1, {31'h0, d[1]});
        rb = fw(1'b0, 1'b0, 4'h5, 2'h3, 14'h0123);
        u_host.frame({rb, fw(1'b0, 1'b0, 4'h5, 2'h3, 14'h0456)}, 48, rx);
        chk("chain_out", {8'h0, rb}, {8'h0, rx[23:0]});
        mem({4'h5, 2'h0}, 14'h0456);
        bus(`OFS_LAST_WORD, 1'b0, 32'h0, d);
        chk("last_word", {8'h0, fw(1'b0, 1'b0, 4'h5, 2'h3, 14'h0456)}, d);
        u_host.frame(48'h3FF, 10, rx);
        bus(`OFS_STATUS, 1'b0, 32'h0, d);
        chk("bad_frames", 32'h1, {24'h0, d[31:24]});
        mem({4'h5, 2'h0}, 14'h0456);
        results;
    end
endmodule
`default_nettype wire
